// ==== rtl/rcog_defines.vh ====
// register offsets, field positions, encodings and reset values of the config/gating block
`ifndef RCOG_DEFINES_VH
`define RCOG_DEFINES_VH

// =====================================================================
// register offsets (byte addresses, one 32-bit word each)
`define RCOG_ADDR_SIGCFG   8'h00
`define RCOG_ADDR_SIGEN    8'h04
`define RCOG_ADDR_PROTO    8'h08
`define RCOG_ADDR_INFEN    8'h0C
`define RCOG_ADDR_ANTCFG   8'h10
`define RCOG_ADDR_ANTSTS   8'h14
`define RCOG_ADDR_IRQSTS   8'h18
`define RCOG_ADDR_IRQMSK   8'h1C
`define RCOG_ADDR_WARNCFG  8'h20
`define RCOG_ADDR_RATE     8'h40

// =====================================================================
// signal configuration: three bits per constellation
`define RCOG_SIG_MASTER    0
`define RCOG_SIG_FIRST     1
`define RCOG_SIG_SECOND    2
`define RCOG_NCONST        5
`define RCOG_CONST_BDS     3
`define RCOG_SIGCFG_RST    15'h5_B6F

// =====================================================================
// output protocols, three enable bits per interface
`define RCOG_PROTO_NMEA    2'h0
`define RCOG_PROTO_BIN     2'h1
`define RCOG_PROTO_RTCM    2'h2
`define RCOG_PROTO_W       3
`define RCOG_PROTO_RST     15'h7_FFF

// =====================================================================
// antenna configuration fields
`define RCOG_ANT_VOLTCTRL  0
`define RCOG_ANT_SHORTDET  1
`define RCOG_ANT_OPENDET   2
`define RCOG_ANT_PWRDOWN   3
`define RCOG_ANT_RECOVER   4
`define RCOG_ANTCFG_RST    5'h00

// antenna power status encoding
`define RCOG_PWR_OFF       2'h0
`define RCOG_PWR_ON        2'h1
`define RCOG_PWR_UNKNOWN   2'h2

// =====================================================================
// interrupt status bits
`define RCOG_IRQ_NAK       0
`define RCOG_IRQ_ANT       1
`define RCOG_IRQ_EPOCH     2
`define RCOG_IRQ_W         3

`endif

// ==== rtl/rcog_sync.v ====
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps

module rcog_sync
#(
  parameter W = 1
)
(
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] pin,
  output reg  [W-1:0] level
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      // s1 is read by s2 only; the qualified level follows agreement of s2 and s3
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1[g]    <= 1'b0;
          s2[g]    <= 1'b0;
          s3[g]    <= 1'b0;
          level[g] <= 1'b0;
        end
        else
        begin
          s1[g] <= pin[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g])
            level[g] <= s3[g];
        end
      end
    end
  endgenerate

endmodule // rcog_sync

// ==== rtl/rcog_top.v ====
// receiver configuration: message rate dividers, output gating, signal checks, antenna supervisor
//
// Contract
// - a message whose rate setting is zero is never emitted
// - nonzero rate N emits the message once every N related events
// - each message on each interface has its own rate setting
// - non-periodic messages go out only in answer to a poll
// - information messages have no divider, only an enable per interface and per information type
// - nothing of a protocol leaves an interface whose protocol enable is clear
// - constellation enabled exactly when master set and at least one signal set
// - first and second band must match; only second BeiDou band may drop alone
// - unsupported signal write gets a nak, plus a warning when enabled
// - voltage-control enable lets the block switch the antenna supply
// - short-detect enable turns on short monitoring of the feed
// - open-detect enable turns on open (disconnected) monitoring
// - power-down-on-short with a detected short cuts the antenna supply while voltage control is enabled
// - every antenna status change sends a notice; status stays readable
// - antenna power status is off, on or unknown
// - every configuration write is answered by ack or nak
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`include "rcog_defines.vh"

module rcog_top
#(
  parameter NIF      = 5,
  parameter NMSG     = 4,
  parameter NINF     = 4,
  parameter RATE_W   = 8,
  parameter MSG_PROTO = 8'b10_00_00_01
)
(
  input  wire                clk,
  input  wire                rst_n,
  input  wire [7:0]          addr,
  input  wire [31:0]         wdata,
  input  wire                wr,
  input  wire                rd,
  output reg  [31:0]         rdata,
  input  wire                epoch_pin,
  input  wire                ant_short_pin,
  input  wire                ant_open_pin,
  input  wire                poll_req,
  input  wire [2:0]          poll_if,
  input  wire [1:0]          poll_msg,
  input  wire                info_req,
  input  wire [1:0]          info_type,
  output reg  [NIF*NMSG-1:0] msg_emit,
  output reg  [NIF*NMSG-1:0] poll_emit,
  output reg  [NIF-1:0]      info_emit,
  output reg  [`RCOG_NCONST-1:0] const_enabled,
  output reg                 cfg_ack,
  output reg                 cfg_nak,
  output reg                 sig_warn,
  output reg                 ant_supply_en,
  output reg                 ant_notice,
  output reg                 irq
);

  localparam NENT = NIF * NMSG;
  localparam CW   = 3 * `RCOG_NCONST;

  // =====================================================================
  // decode helpers
  function rate_hit;
    input [7:0] a;
    begin
      rate_hit = (a >= `RCOG_ADDR_RATE) && (a < `RCOG_ADDR_RATE + 4 * NENT)
                 && (a[1:0] == 2'b00);
    end
  endfunction

  function [7:0] rate_idx;
    input [7:0] a;
    begin
      rate_idx = (a - `RCOG_ADDR_RATE) >> 2;
    end
  endfunction

  // true when every constellation keeps both bands matched, BeiDou second band excepted
  function sig_ok;
    input [CW-1:0] c;
    integer k;
    reg f;
    reg s;
    begin
      sig_ok = 1'b1;
      for (k = 0; k < `RCOG_NCONST; k = k + 1)
      begin
        f = c[3*k + `RCOG_SIG_FIRST];
        s = c[3*k + `RCOG_SIG_SECOND];
        if (f != s)
        begin
          if (!(k == `RCOG_CONST_BDS && f && !s))
            sig_ok = 1'b0;
        end
      end
    end
  endfunction

  // =====================================================================
  // pin synchronisers
  wire [2:0] pins_s;

  rcog_sync #(.W(3)) u_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({ant_open_pin, ant_short_pin, epoch_pin}),
    .level (pins_s)
  );

  wire epoch_s = pins_s[0];
  wire short_s = pins_s[1];
  wire open_s  = pins_s[2];

  reg  epoch_d;
  wire epoch_evt = epoch_s & ~epoch_d;

  // =====================================================================
  // configuration registers
  reg  [CW-1:0]          sig_cfg;
  reg  [NIF*3-1:0]       proto_en;
  reg  [NIF*NINF-1:0]    info_en;
  reg  [4:0]             ant_cfg;
  reg  [`RCOG_IRQ_W-1:0] irq_sts;
  reg  [`RCOG_IRQ_W-1:0] irq_msk;
  reg                    warn_en;
  reg  [1:0]             pwr_state;
  reg                    short_flag;
  reg                    open_flag;
  reg  [3:0]             ant_prev;

  wire wr_sig  = wr && (addr == `RCOG_ADDR_SIGCFG);
  wire sig_bad = wr_sig && !sig_ok(wdata[CW-1:0]);
  wire rate_wr = wr && rate_hit(addr);
  wire [7:0] rate_wi = rate_idx(addr);
  wire [3:0] ant_now = {pwr_state, short_flag, open_flag};
  wire ant_chg = (ant_now != ant_prev);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sig_cfg  <= `RCOG_SIGCFG_RST;
      proto_en <= `RCOG_PROTO_RST;
      info_en  <= {(NIF*NINF){1'b0}};
      ant_cfg  <= `RCOG_ANTCFG_RST;
      irq_msk  <= {`RCOG_IRQ_W{1'b0}};
      warn_en  <= 1'b0;
      cfg_ack  <= 1'b0;
      cfg_nak  <= 1'b0;
      sig_warn <= 1'b0;
    end
    else
    begin
      // a rejected signal write leaves the old configuration in force
      if (wr_sig && !sig_bad)
        sig_cfg <= wdata[CW-1:0];
      if (wr && (addr == `RCOG_ADDR_PROTO))
        proto_en <= wdata[NIF*3-1:0];
      if (wr && (addr == `RCOG_ADDR_INFEN))
        info_en <= wdata[NIF*NINF-1:0];
      if (wr && (addr == `RCOG_ADDR_ANTCFG))
        ant_cfg <= wdata[4:0];
      if (wr && (addr == `RCOG_ADDR_IRQMSK))
        irq_msk <= wdata[`RCOG_IRQ_W-1:0];
      if (wr && (addr == `RCOG_ADDR_WARNCFG))
        warn_en <= wdata[0];
      cfg_ack  <= wr && !sig_bad;
      cfg_nak  <= sig_bad;
      sig_warn <= sig_bad && warn_en;
    end
  end

  // =====================================================================
  // rate dividers, one per message per interface
  wire [NENT*RATE_W-1:0] rate_flat;
  wire [NENT-1:0]        emit_flat;

  genvar i;
  generate
    for (i = 0; i < NENT; i = i + 1)
    begin : g_div
      localparam IF_N = i / NMSG;
      localparam MS_N = i % NMSG;
      reg [RATE_W-1:0] rate_q;
      reg [RATE_W-1:0] cnt_q;
      reg              emit_q;
      wire [1:0] pr = MSG_PROTO[2*MS_N +: 2];
      wire pen = proto_en[IF_N*3 + pr];

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rate_q <= {RATE_W{1'b0}};
          cnt_q  <= {RATE_W{1'b0}};
          emit_q <= 1'b0;
        end
        else
        begin
          emit_q <= 1'b0;
          if (rate_wr && (rate_wi == i))
          begin
            rate_q <= wdata[RATE_W-1:0];
            cnt_q  <= {RATE_W{1'b0}};
          end
          else if (epoch_evt && (rate_q != {RATE_W{1'b0}}))
          begin
            if (cnt_q == rate_q - 1'b1)
            begin
              cnt_q  <= {RATE_W{1'b0}};
              emit_q <= pen;
            end
            else
              cnt_q <= cnt_q + 1'b1;
          end
        end
      end

      assign rate_flat[i*RATE_W +: RATE_W] = rate_q;
      assign emit_flat[i] = emit_q;
    end
  endgenerate

  // =====================================================================
  // message outputs: periodic, polled and information
  reg [NENT-1:0] next_poll;
  reg [NIF-1:0]  next_info;
  integer j;
  integer m;

  always @*
  begin
    next_poll = {NENT{1'b0}};
    next_info = {NIF{1'b0}};
    for (j = 0; j < NIF; j = j + 1)
    begin
      // polled replies are binary-protocol messages
      if (poll_req && (poll_if == j) && proto_en[j*3 + `RCOG_PROTO_BIN])
        next_poll[j*NMSG + poll_msg] = 1'b1;
      if (info_req && info_en[j*NINF + info_type]
          && proto_en[j*3 + `RCOG_PROTO_BIN])
        next_info[j] = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msg_emit      <= {NENT{1'b0}};
      poll_emit     <= {NENT{1'b0}};
      info_emit     <= {NIF{1'b0}};
      const_enabled <= {`RCOG_NCONST{1'b0}};
      epoch_d       <= 1'b0;
    end
    else
    begin
      msg_emit  <= emit_flat;
      poll_emit <= next_poll;
      info_emit <= next_info;
      epoch_d   <= epoch_s;
      for (m = 0; m < `RCOG_NCONST; m = m + 1)
        const_enabled[m] <= sig_cfg[3*m + `RCOG_SIG_MASTER]
                            & (sig_cfg[3*m + `RCOG_SIG_FIRST]
                               | sig_cfg[3*m + `RCOG_SIG_SECOND]);
    end
  end

  // =====================================================================
  // antenna supervisor
  wire voltctrl = ant_cfg[`RCOG_ANT_VOLTCTRL];
  wire shortdet = ant_cfg[`RCOG_ANT_SHORTDET];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ant_supply_en <= 1'b1;
      pwr_state     <= `RCOG_PWR_UNKNOWN;
      short_flag    <= 1'b0;
      open_flag     <= 1'b0;
      ant_prev      <= {`RCOG_PWR_UNKNOWN, 2'b00};
      ant_notice    <= 1'b0;
    end
    else
    begin
      short_flag <= shortdet && short_s;
      open_flag  <= ant_cfg[`RCOG_ANT_OPENDET] && open_s;
      if (!voltctrl)
      begin
        // without voltage control the supply is not managed, so its state is not known
        ant_supply_en <= 1'b1;
        pwr_state     <= `RCOG_PWR_UNKNOWN;
      end
      else
      begin
        if (short_flag && ant_cfg[`RCOG_ANT_PWRDOWN])
          ant_supply_en <= 1'b0;
        else if (!ant_supply_en && ant_cfg[`RCOG_ANT_RECOVER] && shortdet
                 && !short_flag)
          ant_supply_en <= 1'b1;
        pwr_state <= ant_supply_en ? `RCOG_PWR_ON : `RCOG_PWR_OFF;
      end
      ant_prev   <= ant_now;
      ant_notice <= ant_chg;
    end
  end

  // =====================================================================
  // interrupt status: sticky, cleared by reading, a new event wins over the clear
  wire [`RCOG_IRQ_W-1:0] irq_evt = {epoch_evt, ant_chg, sig_bad};
  wire irq_rd = rd && (addr == `RCOG_ADDR_IRQSTS);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_sts <= {`RCOG_IRQ_W{1'b0}};
      irq     <= 1'b0;
    end
    else
    begin
      irq_sts <= (irq_rd ? {`RCOG_IRQ_W{1'b0}} : irq_sts) | irq_evt;
      irq     <= |(irq_sts & irq_msk);
    end
  end

  // =====================================================================
  // register read port, data one cycle after the strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      rdata <= 32'h0000_0000;
      if (addr == `RCOG_ADDR_SIGCFG)
        rdata[CW-1:0] <= sig_cfg;
      else if (addr == `RCOG_ADDR_SIGEN)
        rdata[`RCOG_NCONST-1:0] <= const_enabled;
      else if (addr == `RCOG_ADDR_PROTO)
        rdata[NIF*3-1:0] <= proto_en;
      else if (addr == `RCOG_ADDR_INFEN)
        rdata[NIF*NINF-1:0] <= info_en;
      else if (addr == `RCOG_ADDR_ANTCFG)
        rdata[4:0] <= ant_cfg;
      else if (addr == `RCOG_ADDR_ANTSTS)
        rdata[4:0] <= {ant_supply_en, ant_now};
      else if (addr == `RCOG_ADDR_IRQSTS)
        rdata[`RCOG_IRQ_W-1:0] <= irq_sts;
      else if (addr == `RCOG_ADDR_IRQMSK)
        rdata[`RCOG_IRQ_W-1:0] <= irq_msk;
      else if (addr == `RCOG_ADDR_WARNCFG)
        rdata[0] <= warn_en;
      else if (rate_hit(addr))
        rdata[RATE_W-1:0] <= rate_flat[rate_idx(addr)*RATE_W +: RATE_W];
    end
    else
      rdata <= 32'h0000_0000;
  end

endmodule // rcog_top

// ==== tb/rcog_field.sv ====
// epoch and antenna sense pin source standing in for the receiver front end
`timescale 1ns/10ps

// ====
// pin source
module rcog_field
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic epoch_go,
  input  wire logic short_on,
  input  wire logic open_on,
  output logic      epoch_pin,
  output logic      ant_short_pin,
  output logic      ant_open_pin
);
  logic [3:0] phase;

  // pin held high six cycles so the three-stage synchroniser cannot miss it
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      phase <= 4'h0;
    else if (phase != 4'h0)
      phase <= phase - 4'h1;
    else if (epoch_go)
      phase <= 4'hC;

  assign epoch_pin     = phase > 4'h6;
  assign ant_short_pin = short_on;
  assign ant_open_pin  = open_on;
endmodule // rcog_field

// ==== tb/rcog_top_monitor.sv ====
// port-level assertions of the configuration and gating block
`timescale 1ns/10ps
`include "rcog_defines.vh"

// ====
// checker
module rcog_chk
(
  input wire        clk,
  input wire        rst_n,
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        poll_req,
  input wire        info_req,
  input wire        ant_short_pin,
  input wire [19:0] poll_emit,
  input wire [4:0]  info_emit,
  input wire        cfg_ack,
  input wire        cfg_nak,
  input wire        sig_warn,
  input wire        ant_supply_en
);
  // only the second band of constellation 3 may be dropped alone
  function automatic logic bad(input logic [31:0] v);
    bad = 1'h0;
    for (int k = 0; k < 5; k++)
      if (v[3*k+1] != v[3*k+2] && !(k == 3 && v[3*k+1]))
        bad = 1'h1;
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sig_wr;
    wr && addr == `RCOG_ADDR_SIGCFG;
  endsequence

  a_nak_excl_ack: assert property (cfg_nak |-> !cfg_ack)
    else $error("ack and nak together");
  a_wr_answered: assert property (wr |=> cfg_ack != cfg_nak)
    else $error("write not answered");
  a_answer_cause: assert property ((cfg_ack || cfg_nak) |-> $past(wr))
    else $error("answer without write");
  a_warn_nak: assert property (sig_warn |-> cfg_nak)
    else $error("warning without nak");
  a_bad_sig_nak: assert property (s_sig_wr ##0 bad(wdata) |=> cfg_nak)
    else $error("bad signal set not refused");
  a_good_sig_ack: assert property (s_sig_wr ##0 !bad(wdata) |=> cfg_ack)
    else $error("good signal set refused");
  a_poll_cause: assert property (|poll_emit |-> $past(poll_req))
    else $error("poll reply without poll");
  a_info_cause: assert property (|info_emit |-> $past(info_req))
    else $error("info without request");
  // the fall is seen six edges after the pin; one of the two synchroniser samples held it
  a_short_cut: assert property ($fell(ant_supply_en) |->
    $past(ant_short_pin, 5) || $past(ant_short_pin, 6))
    else $error("supply cut without short");
endmodule // rcog_chk

bind rcog_top rcog_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .poll_req(poll_req), .info_req(info_req), .ant_short_pin(ant_short_pin),
  .poll_emit(poll_emit), .info_emit(info_emit), .cfg_ack(cfg_ack), .cfg_nak(cfg_nak),
  .sig_warn(sig_warn), .ant_supply_en(ant_supply_en));

// ==== tb/test_receiver_config_output_gating.sv ====
// self-checking bench of the configuration and gating block
`timescale 1ns/10ps
`include "rcog_defines.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %0h got %0h", n, e, g); end end

// ====
// bench
module test_receiver_config_output_gating;
  logic        clk, rst_n, wr, rd, epoch_go, short_on, open_on, poll_req, info_req;
  logic        epoch_pin, ant_short_pin, ant_open_pin, cfg_ack, cfg_nak, sig_warn;
  logic        ant_supply_en, ant_notice, irq, ack, nak, warn;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [2:0]  poll_if;
  logic [1:0]  poll_msg, info_type;
  logic [19:0] msg_emit, poll_emit;
  logic [4:0]  info_emit, const_enabled;
  logic [14:0] cur;
  int          fails, n_tests, ncnt, mcnt[20], ex[20];
  logic [7:0]  ra[6] = '{`RCOG_ADDR_SIGCFG, `RCOG_ADDR_PROTO, `RCOG_ADDR_ANTCFG,
                         `RCOG_ADDR_RATE, `RCOG_ADDR_IRQMSK, 8'h3C};
  logic [31:0] rv[6] = '{`RCOG_SIGCFG_RST, `RCOG_PROTO_RST, `RCOG_ANTCFG_RST, 0, 0, 0};

  rcog_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .epoch_pin(epoch_pin), .ant_short_pin(ant_short_pin),
    .ant_open_pin(ant_open_pin), .poll_req(poll_req), .poll_if(poll_if),
    .poll_msg(poll_msg), .info_req(info_req), .info_type(info_type),
    .msg_emit(msg_emit), .poll_emit(poll_emit), .info_emit(info_emit),
    .const_enabled(const_enabled), .cfg_ack(cfg_ack), .cfg_nak(cfg_nak),
    .sig_warn(sig_warn), .ant_supply_en(ant_supply_en), .ant_notice(ant_notice), .irq(irq));

  rcog_field far (.clk(clk), .rst_n(rst_n), .epoch_go(epoch_go), .short_on(short_on),
    .open_on(open_on), .epoch_pin(epoch_pin), .ant_short_pin(ant_short_pin),
    .ant_open_pin(ant_open_pin));

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    ncnt += ant_notice;
    for (int i = 0; i < 20; i++)
      mcnt[i] += msg_emit[i];
  end

  function automatic logic [4:0] cen(input logic [14:0] v);
    for (int k = 0; k < 5; k++)
      cen[k] = v[3*k] & (v[3*k+1] | v[3*k+2]);
  endfunction

  function automatic logic good(input logic [14:0] v);
    good = 1'h1;
    for (int k = 0; k < 5; k++)
      if (v[3*k+1] != v[3*k+2] && !(k == 3 && v[3*k+1]))
        good = 1'h0;
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    #1;
    ack  = cfg_ack;
    nak  = cfg_nak;
    warn = sig_warn;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    v = rdata;
  endtask

  task automatic sig_try(input logic [14:0] v);
    logic ok;
    ok = good(v);
    wr_reg(`RCOG_ADDR_SIGCFG, {17'h0_0000, v});
    `CHK("ack", ok, ack)
    `CHK("nak", !ok, nak)
    `CHK("warn", !ok, warn)
    if (ok)
      cur = v;
    rd_reg(`RCOG_ADDR_SIGCFG, d);
    `CHK("sigcfg", {17'h0_0000, cur}, d)
    `CHK("const_enabled", cen(cur), const_enabled)
  endtask

  task automatic epochs(input int n);
    repeat (n)
    begin
      @(posedge clk);
      epoch_go <= 1'h1;
      @(posedge clk);
      epoch_go <= 1'h0;
      repeat (16) @(posedge clk);
    end
    #1;
  endtask

  task automatic chk_rates;
    for (int i = 0; i < 20; i++)
      `CHK("emits", ex[i], mcnt[i])
    mcnt = '{default: 0};
    ex   = '{default: 0};
  endtask

  task automatic wait_sup(input logic v);
    for (int n = 0; n < 30 && ant_supply_en !== v; n++)
      @(posedge clk);
    #1;
    `CHK("supply", v, ant_supply_en)
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    finish_test;
  end

  initial
  begin
    {rst_n, wr, rd, epoch_go, short_on, open_on, poll_req, info_req} = '0;
    {addr, wdata, poll_if, poll_msg, info_type} = '0;
    cur = `RCOG_SIGCFG_RST;
    mcnt = '{default: 0};
    ex = '{default: 0};
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(ra[i], d);
      `CHK("reset value", rv[i], d)
    end
    `CHK("const_enabled", cen(cur), const_enabled)
    wr_reg(8'h3C, 32'h0000_FFFF);
    `CHK("unmapped ack", 1'h1, ack)
    wr_reg(`RCOG_ADDR_WARNCFG, 32'h0000_0001);
    wr_reg(`RCOG_ADDR_IRQMSK, 32'h0000_0001);
    sig_try(15'h7FFF);
    for (int c = 0; c < 8; c++)
      sig_try({cur[14:3], c[2:0]});
    sig_try({cur[14:12], 3'h3, cur[8:0]});
    sig_try({cur[14:12], 3'h5, cur[8:0]});
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq", 1'h1, irq)
    rd_reg(`RCOG_ADDR_IRQSTS, d);
    `CHK("nak status", 1'h1, d[`RCOG_IRQ_NAK])
    wr_reg(`RCOG_ADDR_IRQMSK, 32'h0000_0000);
    sig_try({cur[14:12], 3'h5, cur[8:0]});
    repeat (2) @(posedge clk);
    #1;
    `CHK("masked irq", 1'h0, irq)
    // rates: if0 msg0 every 2nd, if1 msg0 every, if2 msg0 every 3rd epoch
    wr_reg(`RCOG_ADDR_RATE, 32'h0000_0002);
    wr_reg(`RCOG_ADDR_RATE + 8'h10, 32'h0000_0001);
    wr_reg(`RCOG_ADDR_RATE + 8'h20, 32'h0000_0003);
    mcnt = '{default: 0};
    epochs(4);
    ex[0] = 2;
    ex[4] = 4;
    ex[8] = 1;
    chk_rates;
    // rewrite restarts if2; binary output off on if1
    wr_reg(`RCOG_ADDR_RATE + 8'h20, 32'h0000_0003);
    wr_reg(`RCOG_ADDR_PROTO, 32'h0000_7FEF);
    mcnt = '{default: 0};
    epochs(2);
    ex[0] = 1;
    chk_rates;
    @(posedge clk);
    poll_req <= 1'h1;
    poll_msg <= 2'h2;
    @(posedge clk);
    poll_if <= 3'h1;
    #1;
    `CHK("poll", 20'h0_0004, poll_emit)
    @(posedge clk);
    poll_req <= 1'h0;
    #1;
    `CHK("poll gated", 20'h0_0000, poll_emit)
    wr_reg(`RCOG_ADDR_INFEN, 32'h0000_0022);
    @(posedge clk);
    info_req  <= 1'h1;
    info_type <= 2'h1;
    @(posedge clk);
    info_type <= 2'h0;
    #1;
    `CHK("info", 5'h01, info_emit)
    @(posedge clk);
    info_req <= 1'h0;
    #1;
    `CHK("info off", 5'h00, info_emit)
    wr_reg(`RCOG_ADDR_ANTCFG, 32'h0000_001F);
    repeat (10) @(posedge clk);
    ncnt = 0;
    short_on <= 1'h1;
    wait_sup(1'h0);
    repeat (4) @(posedge clk);
    rd_reg(`RCOG_ADDR_ANTSTS, d);
    `CHK("status short", 32'h0000_0002, d)
    @(posedge clk);
    short_on <= 1'h0;
    wait_sup(1'h1);
    @(posedge clk);
    open_on <= 1'h1;
    repeat (8) @(posedge clk);
    rd_reg(`RCOG_ADDR_ANTSTS, d);
    `CHK("status open", 32'h0000_0015, d)
    `CHK("notices", 5, ncnt)
    @(posedge clk);
    open_on <= 1'h0;
    wr_reg(`RCOG_ADDR_ANTCFG, 32'h0000_0000);
    repeat (8) @(posedge clk);
    rd_reg(`RCOG_ADDR_ANTSTS, d);
    `CHK("status unknown", 32'h0000_0018, d)
    finish_test;
  end
endmodule // test_receiver_config_output_gating
